// >>> lpss_pkg.sv
// Purpose: Shared constants and types of the panel power-save sequencer
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   Field positions of the control word match lpss_ctrl_t
package lpss_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int unsigned PS_LSB = 0;
  localparam int unsigned HWCFG_BIT = 2;
  localparam int unsigned GPIOCFG_BIT = 3;
  localparam int unsigned GPIO_LSB = 4;

  // ---------------------------------------------------------------
  // Encodings and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] PS_NORMAL = 2'h3;
  localparam logic [1:0] PS_SAVE = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned SEQ_FRAMES = 127;

  // Operating mode as decoded from field and pin
  typedef enum logic [1:0] {
    MODE_SW = 2'h0,
    MODE_RSV = 2'h1,
    MODE_NORMAL = 2'h2,
    MODE_HW = 2'h3
  } lpss_mode_t;

  // Panel sequence, Gray coded along off-up-on-down
  typedef enum logic [1:0] {
    SEQ_OFF = 2'h0,
    SEQ_UP = 2'h1,
    SEQ_ON = 2'h3,
    SEQ_DOWN = 2'h2
  } lpss_seq_t;

  // Control register word
  typedef struct packed {
    logic [3:0] gpio_out;
    logic gpio_cfg;
    logic hw_cfg;
    logic [1:0] ps;
  } lpss_ctrl_t;

  // Panel interface outputs
  typedef struct packed {
    logic power;
    logic [11:0] data;
    logic shift;
    logic line;
    logic frame;
    logic valid;
  } lpss_panel_t;

endpackage : lpss_pkg

// >>> lpss_sync.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is a level, or a Gray-coded or quasi-static word
// Notes:   First stage feeds only the second stage
module lpss_sync #(
  parameter int unsigned W = 1
) (
  // Destination clock
  input wire logic clk,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Plain shift; no reset so a reset level can pass through too
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end

endmodule : lpss_sync

// >>> lpss_frame_gen.sv
// Purpose: Line and frame timing for the panel sequencer
// Assumes: Runs on the pixel clock, synchronous active-low reset
// Notes:   Counters park at zero whenever run is low
module lpss_frame_gen #(
  parameter int unsigned H_TOTAL = 400,
  parameter int unsigned H_ACTIVE = 320,
  parameter int unsigned V_TOTAL = 250,
  parameter int unsigned V_ACTIVE = 240
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  // Timing
  output logic line,
  output logic frame,
  output logic active,
  output logic tick
);

  localparam int unsigned HW = $clog2(H_TOTAL);
  localparam int unsigned VW = $clog2(V_TOTAL);

  logic [HW-1:0] h_q, h_d;
  logic [VW-1:0] v_q, v_d;

  // Decode of the current position
  assign line = (h_q == HW'(H_TOTAL - 1));
  assign frame = (v_q == VW'(V_TOTAL - 1));
  assign active = (h_q < HW'(H_ACTIVE)) && (v_q < VW'(V_ACTIVE));
  assign tick = line && frame;

  // Next position
  always_comb begin
    h_d = h_q + HW'(1);
    v_d = v_q;
    if (line) begin
      h_d = '0;
      v_d = frame ? '0 : v_q + VW'(1);
    end
    if (!run) begin
      h_d = '0;
      v_d = '0;
    end
  end

  always_ff @(posedge pclk) begin
    if (!rst_n) begin
      h_q <= '0;
      v_q <= '0;
    end else begin
      h_q <= h_d;
      v_q <= v_d;
    end
  end

endmodule : lpss_frame_gen

// >>> lpss_top.sv
// Purpose: Power-save mode control and panel power sequencing
// Assumes: AXI4-Lite on aclk, panel logic on its own pixel clock
// Notes:   Mode is decided on aclk; the sequence runs on pclk
//
// Notes on behaviour
// - Pin wins if enabled; field 11 normal, 00 save
// - Software save: panel off, refresh stops
// - Software save: registers usable, lookup table barred
// - Hardware save: host interface fully disabled
// - Any save: sequencer stopped, panel outputs low except GPIO-driven upper data pins
// - GPIO upper data pins keep prior level
// - After reset power inactive, outputs low
// - Writing 11 powers up; sequence lasts 127 frames
// - Power down entering save, up leaving it
module lpss_top import lpss_pkg::*; #(
  parameter int unsigned SEQ_LEN = SEQ_FRAMES,
  parameter int unsigned H_TOTAL = 400,
  parameter int unsigned H_ACTIVE = 320,
  parameter int unsigned V_TOTAL = 250,
  parameter int unsigned V_ACTIVE = 240
) (
  // Register bus clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Hardware power-save pin and access gates
  input wire logic hw_power_save_in,
  output logic host_access_en,
  output logic lut_access_en,
  // Pixel side
  input wire logic pclk,
  input wire logic [11:0] pixel_data,
  output logic display_refresh_en,
  output lpss_panel_t panel_o
);

  localparam int unsigned CW = $clog2(SEQ_LEN + 1);

  // ---------------------------------------------------------------
  // Register bus domain
  // ---------------------------------------------------------------
  logic hw_pin_s;
  logic [1:0] seq_raw;
  lpss_seq_t seq_a;
  lpss_seq_t seq_q, seq_d;

  lpss_sync #(.W(1)) u_hw_sync (
    .clk(aclk),
    .d(hw_power_save_in),
    .q(hw_pin_s)
  );

  // Gray-coded state; each step flips one bit except UP to DOWN, which flips both
  lpss_sync #(.W(2)) u_seq_sync (
    .clk(aclk),
    .d(seq_q),
    .q(seq_raw)
  );
  assign seq_a = lpss_seq_t'(seq_raw);

  lpss_ctrl_t ctrl_q, ctrl_d;
  lpss_mode_t mode_q, mode_d;
  logic host_en_d, lut_en_d, want_q, want_d;

  // Mode decode; reserved codes behave as a save mode
  always_comb begin
    if (ctrl_q.hw_cfg && hw_pin_s) begin
      mode_d = MODE_HW;
    end else begin
      case (ctrl_q.ps)
        PS_NORMAL: mode_d = MODE_NORMAL;
        PS_SAVE: mode_d = MODE_SW;
        default: mode_d = MODE_RSV;
      endcase
    end
    host_en_d = (mode_d != MODE_HW);
    lut_en_d = (mode_d == MODE_NORMAL);
    want_d = (mode_d == MODE_NORMAL);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MODE_SW;
      host_access_en <= 1'b0;
      lut_access_en <= 1'b0;
      want_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      host_access_en <= host_en_d;
      lut_access_en <= lut_en_d;
      want_q <= want_d;
    end
  end

  // Write channel state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_d, awready_d, wready_d, wr_do;
  logic [1:0] bresp_d;

  // Address and data are held until both are in, then one write
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = s_axi_bvalid && !s_axi_bready;
    bresp_d = s_axi_bresp;
    ctrl_d = ctrl_q;
    wr_do = aw_have_q && w_have_q && !s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_do) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_SLVERR;
      // Interface is dead in hardware save, writes dropped
      if (mode_q != MODE_HW && awaddr_q == CTRL_OFS) begin
        bresp_d = RESP_OKAY;
        if (wstrb_q[0]) begin
          ctrl_d = lpss_ctrl_t'(wdata_q[7:0]);
        end
      end
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      ctrl_q <= lpss_ctrl_t'(CTRL_RST);
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Read channel: answer lands on the edge that takes the address
  logic rvalid_d, arready_d;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;

  always_comb begin
    rvalid_d = s_axi_rvalid && !s_axi_rready;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = 32'h0000_0000;
      rresp_d = RESP_OKAY;
      if (mode_q == MODE_HW) begin
        rresp_d = RESP_SLVERR;
      end else if (s_axi_araddr == CTRL_OFS) begin
        rdata_d[7:0] = ctrl_q;
      end else if (s_axi_araddr == STAT_OFS) begin
        rdata_d[4:0] = {hw_pin_s, seq_a, mode_q};
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
      s_axi_arready <= arready_d;
    end
  end

  // ---------------------------------------------------------------
  // Pixel clock domain
  // ---------------------------------------------------------------
  logic prst_n, want_s, gpio_cfg_s;
  logic [3:0] gpio_out_s;
  logic line, frame, active, tick, done, run;
  logic [CW-1:0] cnt_q, cnt_d;
  lpss_panel_t panel_d;
  logic refresh_d;

  // Reset is brought over as a level and used synchronously
  lpss_sync #(.W(1)) u_rst_sync (
    .clk(pclk),
    .d(aresetn),
    .q(prst_n)
  );

  // GPIO levels are quasi-static settings
  lpss_sync #(.W(6)) u_cfg_sync (
    .clk(pclk),
    .d({want_q, ctrl_q.gpio_cfg, ctrl_q.gpio_out}),
    .q({want_s, gpio_cfg_s, gpio_out_s})
  );

  // Timing restarts as power-down begins, so the count spans whole frames
  assign run = ((seq_q != SEQ_OFF) || want_s)
    && !(seq_q == SEQ_ON && !want_s);

  lpss_frame_gen #(
    .H_TOTAL(H_TOTAL),
    .H_ACTIVE(H_ACTIVE),
    .V_TOTAL(V_TOTAL),
    .V_ACTIVE(V_ACTIVE)
  ) u_frame (
    .pclk(pclk),
    .rst_n(prst_n),
    .run(run),
    .line(line),
    .frame(frame),
    .active(active),
    .tick(tick)
  );

  assign done = tick && (cnt_q == CW'(SEQ_LEN - 1));

  // Sequencer: UP and DOWN are left only at the end of a whole count; OFF and ON move at once on want_s
  always_comb begin
    seq_d = seq_q;
    cnt_d = cnt_q;
    case (seq_q)
      SEQ_OFF: begin
        cnt_d = '0;
        if (want_s) seq_d = SEQ_UP;
      end
      SEQ_UP: begin
        if (tick) cnt_d = cnt_q + CW'(1);
        if (done) begin
          cnt_d = '0;
          seq_d = want_s ? SEQ_ON : SEQ_DOWN;
        end
      end
      SEQ_ON: begin
        cnt_d = '0;
        if (!want_s) seq_d = SEQ_DOWN;
      end
      SEQ_DOWN: begin
        if (tick) cnt_d = cnt_q + CW'(1);
        if (done) begin
          cnt_d = '0;
          seq_d = SEQ_OFF;
        end
      end
      default: begin
        seq_d = SEQ_OFF;
        cnt_d = '0;
      end
    endcase
  end

  // Panel drive; power only while fully up to protect the glass
  always_comb begin
    panel_d = '0;
    refresh_d = (seq_q != SEQ_OFF);
    if (seq_q != SEQ_OFF) begin
      panel_d.shift = ~panel_o.shift;
      panel_d.line = line;
      panel_d.frame = frame;
      panel_d.valid = active;
      panel_d.data = active ? pixel_data : 12'h000;
      panel_d.power = (seq_q == SEQ_ON);
    end
    if (gpio_cfg_s) begin
      if (seq_q != SEQ_OFF) begin
        panel_d.data[11:8] = gpio_out_s;
      end else begin
        panel_d.data[11:8] = panel_o.data[11:8];
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (!prst_n) begin
      seq_q <= SEQ_OFF;
      cnt_q <= '0;
      panel_o <= '0;
      display_refresh_en <= 1'b0;
    end else begin
      seq_q <= seq_d;
      cnt_q <= cnt_d;
      panel_o <= panel_d;
      display_refresh_en <= refresh_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  mode_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q.hw_cfg && hw_pin_s) |=> (mode_q == MODE_HW))
    else $error("pin did not force hardware save");
  mode_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!(ctrl_q.hw_cfg && hw_pin_s) && ctrl_q.ps == PS_SAVE)
    |=> (mode_q == MODE_SW))
    else $error("field 00 did not select software save");
  lut_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_q != MODE_NORMAL) |-> !lut_access_en)
    else $error("lookup table open outside normal mode");
  host_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_do && mode_q == MODE_HW)
    |=> (s_axi_bresp == RESP_SLVERR) && $stable(ctrl_q))
    else $error("write accepted in hardware save");
  panel_low_a: assert property (@(posedge pclk) disable iff (!prst_n)
    $past(seq_q) == SEQ_OFF |-> !panel_o.power && !panel_o.line
    && !panel_o.frame && !panel_o.valid && !display_refresh_en)
    else $error("panel active while sequencer off");
  gpio_hold_a: assert property (@(posedge pclk) disable iff (!prst_n)
    (seq_q == SEQ_OFF && gpio_cfg_s)
    |=> $stable(panel_o.data[11:8]))
    else $error("gpio level lost in save");
  seq_len_a: assert property (@(posedge pclk) disable iff (!prst_n)
    (seq_q == SEQ_UP && !done) |=> (seq_q == SEQ_UP))
    else $error("power-up left before full count");
  seq_end_a: assert property (@(posedge pclk) disable iff (!prst_n)
    (seq_q == SEQ_DOWN && done) |=> (seq_q == SEQ_OFF) && (cnt_q == '0))
    else $error("power-down did not finish on count");
  seq_down_a: assert property (@(posedge pclk) disable iff (!prst_n)
    (seq_q == SEQ_ON && !want_s) |=> (seq_q == SEQ_DOWN) ##1
    !panel_o.power)
    else $error("save entry did not start power-down");

endmodule : lpss_top

// >>> lpss_panel_model.sv
// Purpose: Panel side of the power-save sequencer: pixel source, frame count
// Assumes: Pixel clock runs freely; frame pulse is active high
// Notes:   Data outside the active area never repeats its last value
module lpss_panel_model import lpss_pkg::*; (
  // Pixel clock
  input wire logic pclk,
  // Panel pins from the sequencer
  input wire lpss_panel_t panel_i,
  // Refresh data and frame count seen
  output logic [11:0] pixel_data,
  output int unsigned frames
);
  timeunit 1ns;
  timeprecision 1ns;

  logic frame_q = 1'b0;
  logic [11:0] pix_q = 12'h5A3;
  int unsigned frames_q = 0;

  // One driver per output
  assign pixel_data = pix_q;
  assign frames = frames_q;

  // ---------------------------------------------------------------
  // Pixel stream and frame counter
  // ---------------------------------------------------------------
  // Inverting outside valid keeps a stale word from passing as good data
  always @(posedge pclk) begin
    pix_q <= panel_i.valid ? pix_q + 12'h001 : ~pix_q;
    if (panel_i.frame && !frame_q) begin
      frames_q <= frames_q + 1;
    end
    frame_q <= panel_i.frame;
  end
endmodule : lpss_panel_model

// >>> testbench.sv
// Purpose: Self-checking bench of the panel power-save sequencer
// Assumes: Short frames and a short sequence keep the run brief
// Notes:   Registers are reached through a minimal AXI4-Lite master
module testbench import lpss_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned SEQ = 2;
  localparam int unsigned FRAME = 32;
  localparam int unsigned LIMIT = 40000;

  logic aclk = 1'b0;
  logic pclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic hw_pin = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic host_en, lut_en, refresh_en;
  lpss_panel_t panel;
  logic [11:0] pix;
  int unsigned frames;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  int c1;
  int unsigned f0;

  // ---------------------------------------------------------------
  // Clocks: bus clock never stopped, pixel clock off in phase
  // ---------------------------------------------------------------
  initial begin
    forever #20 aclk = ~aclk;
  end
  initial begin
    #37;
    forever #80 pclk = ~pclk;
  end

  lpss_top #(.SEQ_LEN(SEQ), .H_TOTAL(8), .H_ACTIVE(6), .V_TOTAL(4),
    .V_ACTIVE(3)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hw_power_save_in(hw_pin),
    .host_access_en(host_en), .lut_access_en(lut_en), .pclk(pclk),
    .pixel_data(pix), .display_refresh_en(refresh_en), .panel_o(panel));

  lpss_panel_model model (.pclk(pclk), .panel_i(panel), .pixel_data(pix),
    .frames(frames));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Sequence length in pixel clocks, with slack for the crossings
  function automatic logic in_len(input int cyc);
    return (cyc + 4 >= SEQ * FRAME) && (cyc <= SEQ * FRAME + 4);
  endfunction : in_len

  // Each channel is released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  // Counts pixel clocks until refresh (pick) or power reaches want
  task automatic wait_pclk(input bit pick, input logic want, output int cyc);
    logic got;
    cyc = 0;
    do begin
      @(posedge pclk);
      cyc++;
      got = pick ? refresh_en : panel.power;
    end while (got !== want && cyc < 4 * FRAME * SEQ);
  endtask : wait_pclk

  task automatic print_verdict;
    $display("Counts: %0d checked, %0d failed", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // A hang counts as a mismatch and closes the run
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      $display("Timeout after %0d cycles", cycles);
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_reg(CTRL_OFS, rd, rs);
    chk("reset ctrl", {24'h0, CTRL_RST}, rd);
    chk("reset panel", 32'h0, {15'h0, panel});
    chk("reset gates", 32'h2, {30'h0, host_en, lut_en});
    repeat (200) @(posedge pclk);
    chk("idle frames", 32'h0, frames);
    chk("idle refresh", 32'h0, {31'h0, refresh_en});
    $display("Test reset done");
    for (int i = 0; i < 3; i++) begin
      wr(CTRL_OFS, 32'(i), rs);
      rd_reg(STAT_OFS, rd, rs);
      chk("mode", (i == 0) ? 32'h0 : 32'h1, {30'h0, rd[1:0]});
      chk("lut gate", 32'h0, {31'h0, lut_en});
    end
    rd_reg(4'h8, rd, rs);
    chk("unmapped", {30'h0, RESP_SLVERR}, {rd[29:0], rs});
    wr(STAT_OFS, 32'h3, rs);
    chk("status write", {30'h0, RESP_SLVERR}, {30'h0, rs});
    chk("save panel", 32'h0, {15'h0, panel});
    $display("Test decode done");
    wr(CTRL_OFS, {30'h0, PS_NORMAL}, rs);
    wait_pclk(1, 1'b1, c1);
    chk("early power", 32'h0, {31'h0, panel.power});
    wait_pclk(0, 1'b1, c1);
    chk("up length", 32'h1, {31'h0, in_len(c1)});
    chk("frames run", SEQ, frames);
    chk("lut open", 32'h1, {31'h0, lut_en});
    rd_reg(STAT_OFS, rd, rs);
    chk("normal on", 32'hE, {28'h0, rd[3:0]});
    $display("Test power up done");
    wr(CTRL_OFS, 32'hAB, rs);
    repeat (8) @(posedge pclk);
    wr(CTRL_OFS, 32'hA8, rs);
    wait_pclk(0, 1'b0, c1);
    chk("power off fast", 32'h1, {31'h0, c1 <= 8});
    wait_pclk(1, 1'b0, c1);
    chk("down length", 32'h1, {31'h0, in_len(c1)});
    repeat (4) @(posedge pclk);
    chk("gpio kept", {15'h0, 1'b0, 4'hA, 12'h0}, {15'h0, panel});
    f0 = frames;
    repeat (100) @(posedge pclk);
    chk("frames stop", f0, frames);
    rd_reg(CTRL_OFS, rd, rs);
    chk("save access", 32'hA8, rd);
    chk("save gates", 32'h2, {30'h0, host_en, lut_en});
    $display("Test power down done");
    wr(CTRL_OFS, 32'h07, rs);
    wait_pclk(0, 1'b1, c1);
    @(posedge aclk);
    hw_pin <= 1'b1;
    wait_pclk(0, 1'b0, c1);
    wait_pclk(1, 1'b0, c1);
    chk("hw down", 32'h1, {31'h0, in_len(c1)});
    chk("hw panel", 32'h0, {15'h0, panel});
    chk("hw gates", 32'h0, {30'h0, host_en, lut_en});
    rd_reg(CTRL_OFS, rd, rs);
    chk("hw read", {30'h0, RESP_SLVERR}, {rd[29:0], rs});
    wr(CTRL_OFS, 32'h03, rs);
    chk("hw write", {30'h0, RESP_SLVERR}, {30'h0, rs});
    @(posedge aclk);
    hw_pin <= 1'b0;
    wait_pclk(0, 1'b1, c1);
    chk("hw up", 32'h1, {31'h0, panel.power});
    rd_reg(CTRL_OFS, rd, rs);
    chk("write dropped", 32'h07, rd);
    wr(CTRL_OFS, 32'h03, rs);
    @(posedge aclk);
    hw_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    rd_reg(STAT_OFS, rd, rs);
    chk("pin ignored", {25'h0, 1'b1, 2'h3, 2'h2, RESP_OKAY}, {rd[29:0], rs});
    chk("still on", 32'h1, {31'h0, panel.power});
    hw_pin <= 1'b0;
    $display("Test hardware save done");
    print_verdict();
  end
endmodule : testbench
